// ---- common/lfs_map.svh ----
/*
  Register offsets, field positions, reset values and timing counts of
  the light-load and fault supervisor. Assumes a 200 MHz system clock.
*/
`ifndef LFS_MAP_SVH
`define LFS_MAP_SVH

`define LFS_CLK_MHZ 200
`define LFS_OFF_CTRL 12'h000
`define LFS_OFF_UVCFG 12'h004
`define LFS_OFF_FREQ 12'h008
`define LFS_OFF_STATUS 12'h00c

`define LFS_CTRL_AF 0
`define LFS_CTRL_DE 1
`define LFS_CTRL_MULTI 2
`define LFS_CTRL_EXTCLK 3
`define LFS_CTRL_SYNCOUT 4
`define LFS_CTRL_OVLOW 5
`define LFS_CTRL_RESTART 6
`define LFS_CTRL_OVRETRY_LSB 8

`define LFS_UV_THR_LSB 0
`define LFS_UV_RESP_LSB 11
`define LFS_UV_RETRY_LSB 13

`define LFS_THR_MIN 11'h11d
`define LFS_THR_MAX 11'h640
`define LFS_THR_LOW 11'h12c
`define LFS_THR_OPEN 11'h1c2
`define LFS_THR_HIGH 11'h438
`define LFS_RETRY_INF 4'hf
`define LFS_RESP_RST 2'h2
`define LFS_PROG_INC_RST 16'h00a4
`define LFS_MIN_INC_RST 16'h0029

`define LFS_OV_NUM 12'h014
`define LFS_OV_DEN 12'h017

`define LFS_DT_MIN 6'h01
`define LFS_DT_MAX 6'h3f
`define LFS_DT_RST 6'h08
`define LFS_TRIM_PERIODS 4'hf

`define LFS_UV_DELAY_US 10
`define LFS_RETRY_DELAY_US 20
`define LFS_UV_DELAY_CYC (`LFS_UV_DELAY_US * `LFS_CLK_MHZ)
`define LFS_RETRY_DELAY_CYC (`LFS_RETRY_DELAY_US * `LFS_CLK_MHZ)

`endif

// ---- common/lfs_pkg.sv ----
/*
  Types of the light-load and fault supervisor.
  Assumes lfs_map.svh for the numeric constants.
*/
package lfs_pkg;
  typedef enum logic [2:0] {
    LFS_STRAP = 3'h0,
    LFS_RUN = 3'h1,
    LFS_RETRY = 3'h3,
    LFS_LATCH = 3'h2,
    LFS_OVLOW = 3'h6
  } lfs_state_e;
  typedef logic [1:0] lfs_strap_t;
endpackage : lfs_pkg

// ---- design/lfs_supervisor.sv ----
/*
  Gate drive timing, dead-time trim, diode emulation, adaptive frequency,
  input low-voltage lockout and output overvoltage supervision, with an
  APB register slave. Assumes synchronous digitised sense inputs, a loop
  duty command as a 16-bit fraction, and strap pins decoded outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lfs_map.svh"

module lfs_supervisor (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lfs_pkg::lfs_strap_t strapLevel,
  input wire logic [4:0] strapIndex,
  input wire logic [10:0] inputVoltage,
  input wire logic [11:0] outputSenseInput,
  input wire logic [11:0] outputTarget,
  input wire logic [15:0] dutyCommand,
  input wire logic [15:0] nominalDuty,
  input wire logic inductorZero,
  output logic highSideGateDrive,
  output logic lowSideGateDrive,
  output logic supplyGoodOutput
);
  import lfs_pkg::*;

  lfs_state_e state;
  lfs_state_e next_state;
  logic afEn, deEn, multiPhase, extClk, syncOut, ovLow;
  logic [3:0] ovRetries;
  logic [10:0] uvThr;
  logic [1:0] uvResp;
  logic [3:0] uvRetries;
  logic [15:0] progInc, minInc, curInc, phase;
  logic [5:0] deadTime;
  logic trimUp;
  logic [3:0] trimCnt;
  logic [19:0] dutySum, prevSum;
  logic zeroSeen;
  logic [11:0] cnt;
  logic [3:0] used;
  logic lastOv;

  // Strap decode, resistor table in 10 mV units
  function automatic logic [10:0] strapThr(input lfs_strap_t lvl, input logic [4:0] idx);
    logic [10:0] t;
    t = `LFS_THR_OPEN;
    unique case (lvl)
      2'h0: t = `LFS_THR_LOW;
      2'h1: t = `LFS_THR_OPEN;
      2'h2: t = `LFS_THR_HIGH;
      2'h3: begin
        case (idx)
          5'h00: t = 11'h11d;
          5'h01: t = 11'h13a;
          5'h02: t = 11'h158;
          5'h03: t = 11'h17b;
          5'h04: t = 11'h1a2;
          5'h05: t = 11'h1cb;
          5'h06: t = 11'h1fa;
          5'h07: t = 11'h22d;
          5'h08: t = 11'h265;
          5'h09: t = 11'h2a3;
          5'h0a: t = 11'h2e6;
          5'h0b: t = 11'h332;
          5'h0c: t = 11'h383;
          5'h0d: t = 11'h3de;
          5'h0e: t = 11'h442;
          5'h0f: t = 11'h4b0;
          5'h10: t = 11'h528;
          5'h11: t = 11'h5ae;
          5'h12: t = 11'h640;
          default: t = `LFS_THR_OPEN;
        endcase
      end
    endcase
    return t;
  endfunction : strapThr

  // APB decode
  wire apbAccess = psel & penable & ~pready;
  wire apbDone = psel & penable & pready;
  wire selCtrl = paddr == `LFS_OFF_CTRL;
  wire selUv = paddr == `LFS_OFF_UVCFG;
  wire selFreq = paddr == `LFS_OFF_FREQ;
  wire selStat = paddr == `LFS_OFF_STATUS;
  wire mapped = selCtrl | selUv | selFreq | selStat;
  wire wrCtrl = apbDone & pwrite & selCtrl;
  wire wrUv = apbDone & pwrite & selUv;
  wire wrFreq = apbDone & pwrite & selFreq;
  wire restartCmd = wrCtrl & pwdata[`LFS_CTRL_RESTART];

  wire [10:0] wrThr = pwdata[`LFS_UV_THR_LSB +: 11];
  wire [10:0] clampThr = (wrThr < `LFS_THR_MIN) ? `LFS_THR_MIN :
                         (wrThr > `LFS_THR_MAX) ? `LFS_THR_MAX : wrThr;

  // Faults
  wire uvFault = inputVoltage < uvThr;
  wire [16:0] ovLhs = outputSenseInput * `LFS_OV_NUM;
  wire [16:0] ovRhs = outputTarget * `LFS_OV_DEN;
  wire ovFault = ovLhs > ovRhs;
  wire ovLowEff = ovLow & ~extClk;
  wire anyFault = ovFault | (uvFault & uvResp != 2'h0);

  // Mode qualification
  wire deEff = deEn & ~multiPhase;
  wire afEff = afEn & deEff & ~(multiPhase & extClk) & ~syncOut;

  // Adaptive frequency: quantised eighths of nominal/2
  wire [19:0] dutyX16 = {dutyCommand, 4'h0};
  wire lightLoad = {dutyCommand, 1'b0} <= {1'b0, nominalDuty};
  logic [3:0] stepK;
  always_comb begin
    stepK = 4'h0;
    for (int j = 1; j < 8; j++) begin
      if (dutyX16 >= 20'(j * nominalDuty)) stepK = stepK + 4'h1;
    end
  end
  wire [15:0] incDiff = (progInc > minInc) ? progInc - minInc : 16'h0000;
  wire [19:0] stepProd = incDiff * stepK;
  wire [15:0] afInc = minInc + stepProd[18:3];
  wire [15:0] next_curInc = (afEff & lightLoad) ? afInc : progInc;

  // Phase accumulator and windows
  wire [16:0] phaseSum = {1'b0, phase} + {1'b0, curInc};
  wire wrap = phaseSum[16];
  wire [21:0] dtProd = deadTime * curInc;
  wire [15:0] dtPh = |dtProd[21:16] ? 16'hffff : dtProd[15:0];
  wire [16:0] lowStart = {1'b0, dutyCommand} + {1'b0, dtPh};
  wire [16:0] lowEnd = 17'h10000 - {1'b0, dtPh};
  wire running = state == LFS_RUN;
  wire hiWin = running & (phase < dutyCommand);
  wire lowWin = running & ({1'b0, phase} >= lowStart) & ({1'b0, phase} < lowEnd)
    & ~(deEff & (zeroSeen | inductorZero));
  wire next_high = hiWin & ~ovFault & ~lowSideGateDrive;
  wire next_low = ((state == LFS_OVLOW) | lowWin) & ~hiWin & ~highSideGateDrive;

  // Dead-time trim from the loop's own duty command
  wire trimEnd = wrap & (trimCnt == `LFS_TRIM_PERIODS);
  wire worse = dutySum > prevSum;
  wire next_trimUp = worse ? ~trimUp : trimUp;
  wire [5:0] next_dt = next_trimUp ?
    ((deadTime == `LFS_DT_MAX) ? deadTime : deadTime + 6'h01) :
    ((deadTime == `LFS_DT_MIN) ? deadTime : deadTime - 6'h01);

  // Fault sequencing
  wire [3:0] retryLim = lastOv ? ovRetries : uvRetries;
  wire retriesOut = (retryLim != `LFS_RETRY_INF) & (used >= retryLim);
  wire uvDelayDone = cnt >= 12'(`LFS_UV_DELAY_CYC - 1);
  wire retryDone = cnt >= 12'(`LFS_RETRY_DELAY_CYC - 1);
  wire waitOff = (state == LFS_RETRY) | (state == LFS_OVLOW);
  logic [11:0] next_cnt;
  always_comb begin
    next_state = state;
    next_cnt = 12'h000;
    unique case (state)
      LFS_STRAP: next_state = LFS_RUN;
      LFS_RUN: begin
        if (ovFault) begin
          next_state = ovLowEff ? LFS_OVLOW : LFS_RETRY;
        end else if (uvFault & uvResp == 2'h1) begin
          next_cnt = cnt + 12'h001;
          if (uvDelayDone) next_state = LFS_LATCH;
        end else if (uvFault & uvResp[1]) begin
          next_state = LFS_RETRY;
        end
      end
      LFS_RETRY, LFS_OVLOW: begin
        if (!anyFault) begin
          next_cnt = cnt + 12'h001;
          if (retryDone) next_state = retriesOut ? LFS_LATCH : LFS_RUN;
        end
      end
      LFS_LATCH: next_state = LFS_LATCH;
      default: next_state = LFS_STRAP;
    endcase
    if (restartCmd && state != LFS_STRAP) begin
      next_state = LFS_RUN;
      next_cnt = 12'h000;
    end
  end
  wire next_good = running & (next_state == LFS_RUN) & ~ovFault & ~uvFault;

  // Read mux
  wire [31:0] ctrlRd = {20'h0, ovRetries, 2'h0, ovLow, syncOut, extClk, multiPhase, deEn, afEn};
  wire [31:0] uvRd = {15'h0, uvRetries, uvResp, uvThr};
  // Status: increment, retries used, dead-time, faults, state
  wire [31:0] statRd = {curInc, used, 1'b0, deadTime,
                        ovFault, uvFault, state};
  wire [31:0] rdMux = selCtrl ? ctrlRd : selUv ? uvRd : selFreq ? {minInc, progInc} :
                      selStat ? statRd : 32'h0;

  // One wait state: ready answers the first access cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apbAccess;
      pslverr <= apbAccess & ~mapped;
      prdata <= apbAccess ? rdMux : 32'h0;
    end
  end

  // Low-side overvoltage response refused under an external clock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {afEn, deEn, multiPhase, extClk, syncOut, ovLow} <= 6'h00;
      ovRetries <= `LFS_RETRY_INF;
    end else if (wrCtrl) begin
      afEn <= pwdata[`LFS_CTRL_AF];
      deEn <= pwdata[`LFS_CTRL_DE];
      multiPhase <= pwdata[`LFS_CTRL_MULTI];
      extClk <= pwdata[`LFS_CTRL_EXTCLK];
      syncOut <= pwdata[`LFS_CTRL_SYNCOUT];
      ovLow <= pwdata[`LFS_CTRL_OVLOW] & ~pwdata[`LFS_CTRL_EXTCLK];
      ovRetries <= pwdata[`LFS_CTRL_OVRETRY_LSB +: 4];
    end
  end

  // A software write beats the strap sample in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      uvThr <= `LFS_THR_OPEN;
      uvResp <= `LFS_RESP_RST;
      uvRetries <= `LFS_RETRY_INF;
    end else if (wrUv) begin
      uvThr <= clampThr;
      uvResp <= pwdata[`LFS_UV_RESP_LSB +: 2];
      uvRetries <= pwdata[`LFS_UV_RETRY_LSB +: 4];
    end else if (state == LFS_STRAP) begin
      uvThr <= strapThr(strapLevel, strapIndex);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      progInc <= `LFS_PROG_INC_RST;
      minInc <= `LFS_MIN_INC_RST;
    end else if (wrFreq) begin
      progInc <= pwdata[15:0];
      minInc <= pwdata[31:16];
    end
  end

  // Zero current seen keeps the low side off until the period wraps
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 16'h0000;
      curInc <= `LFS_PROG_INC_RST;
      zeroSeen <= 1'b0;
    end else begin
      phase <= phaseSum[15:0];
      if (wrap) curInc <= next_curInc;
      zeroSeen <= wrap ? 1'b0 : (zeroSeen | (lowSideGateDrive & inductorZero));
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      deadTime <= `LFS_DT_RST;
      trimUp <= 1'b0;
      trimCnt <= 4'h0;
      dutySum <= 20'h0;
      prevSum <= 20'hfffff;
    end else if (wrap) begin
      trimCnt <= trimCnt + 4'h1;
      dutySum <= trimEnd ? 20'h0 : dutySum + {4'h0, dutyCommand};
      if (trimEnd) begin
        prevSum <= dutySum;
        trimUp <= next_trimUp;
        deadTime <= next_dt;
      end
    end
  end

  // Retry count saturates; a restart clears it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= LFS_STRAP;
      cnt <= 12'h000;
      used <= 4'h0;
      lastOv <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      if (restartCmd) begin
        used <= 4'h0;
      end else if (waitOff & next_state == LFS_RUN & used != 4'hf) begin
        used <= used + 4'h1;
      end
      if (running & ovFault) lastOv <= 1'b1;
      else if (running & uvFault) lastOv <= 1'b0;
    end
  end

  // Each gate waits for the other's flop to drop
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      highSideGateDrive <= 1'b0;
      lowSideGateDrive <= 1'b0;
      supplyGoodOutput <= 1'b0;
    end else begin
      highSideGateDrive <= next_high;
      lowSideGateDrive <= next_low;
      supplyGoodOutput <= next_good;
    end
  end

endmodule : lfs_supervisor
`default_nettype wire

// ---- sim/lfs_supervisor_props.sv ----
/* Port checker of lfs_supervisor.
   Assumes the bind at the foot and the map header. */
`timescale 1ns/1ps
`default_nettype none
`include "lfs_map.svh"
module lfs_supervisor_props (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [10:0] inputVoltage,
  input wire logic [11:0] outputSenseInput,
  input wire logic [11:0] outputTarget,
  input wire logic highSideGateDrive,
  input wire logic lowSideGateDrive,
  input wire logic supplyGoodOutput
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [1:0] sinceRst;
  wire logic overV = {5'h0, outputSenseInput} * 17'h14 > {5'h0, outputTarget} * 17'h17;
  wire logic unmapped = paddr > `LFS_OFF_STATUS || paddr[1:0] != 2'h0;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) sinceRst <= 2'h0;
    else if (sinceRst != 2'h3) sinceRst <= sinceRst + 2'h1;
  end
  property p_overlap; !(highSideGateDrive && lowSideGateDrive); endproperty
  property p_gap; $rose(highSideGateDrive) |-> !$past(lowSideGateDrive); endproperty
  property p_quiet;
    sinceRst < 2'h2 |-> !(highSideGateDrive || lowSideGateDrive || supplyGoodOutput);
  endproperty
  property p_ov_good; overV |=> !supplyGoodOutput; endproperty
  property p_ov_off; overV |=> ##1 !highSideGateDrive; endproperty
  property p_uv_good; inputVoltage < `LFS_THR_MIN |=> !supplyGoodOutput; endproperty
  property p_wait; psel && penable && !pready |=> pready; endproperty
  property p_pulse; pready |-> psel && penable ##1 !pready; endproperty
  property p_err; pready && unmapped |-> pslverr; endproperty
  property p_err_cause; pslverr |-> pready && unmapped; endproperty
  property p_idle; !pready || pslverr |-> prdata == 32'h0; endproperty
  a_overlap: assert property (p_overlap) else $error("gates overlap");
  a_gap: assert property (p_gap) else $error("no dead time");
  a_quiet: assert property (p_quiet) else $error("early drive");
  a_ov_good: assert property (p_ov_good) else $error("good kept on ov");
  a_ov_off: assert property (p_ov_off) else $error("high on in ov");
  a_uv_good: assert property (p_uv_good) else $error("good kept on uv");
  a_wait: assert property (p_wait) else $error("late ready");
  a_pulse: assert property (p_pulse) else $error("bad ready");
  a_err: assert property (p_err) else $error("no error");
  a_err_cause: assert property (p_err_cause) else $error("false error");
  a_idle: assert property (p_idle) else $error("stray data");
  c_ov: cover property (overV ##1 !supplyGoodOutput);
  c_err: cover property (pslverr);
  c_low: cover property ($rose(lowSideGateDrive));
endmodule : lfs_supervisor_props
bind lfs_supervisor lfs_supervisor_props u_props (.sys_clk, .arst_n, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .inputVoltage, .outputSenseInput, .outputTarget,
  .highSideGateDrive, .lowSideGateDrive, .supplyGoodOutput);
`default_nettype wire

// ---- sim/lfs_power_stage.sv ----
/* Power stage model: inductor current reaches zero after lightLoad
   cycles of low-side conduction. Assumes registered gate drives. */
`timescale 1ns/1ps
`default_nettype none
module lfs_power_stage (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic highSideGateDrive,
  input wire logic lowSideGateDrive,
  input wire logic [7:0] lightLoad,
  output logic inductorZero
);
  logic [7:0] lowOn;
  // Zero stays until the next high-side pulse; 0 means heavy load
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) lowOn <= 8'h0;
    else if (highSideGateDrive) lowOn <= 8'h0;
    else if (lowSideGateDrive && lowOn != 8'hff) lowOn <= lowOn + 8'h1;
  end
  assign inductorZero = lightLoad != 8'h0 && lowOn >= lightLoad;
endmodule : lfs_power_stage
`default_nettype wire

// ---- sim/tb_lfs_supervisor.sv ----
/* Testbench of lfs_supervisor with the power stage model.
   Assumes package, map header and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "lfs_map.svh"
module tb_lfs_supervisor;
  import lfs_pkg::*;
  typedef struct {logic [1:0] lv; logic [4:0] ix; logic [11:0] a; logic wr;
    logic [31:0] d; logic [31:0] q;} lfs_row_s;
  logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, er, inductorZero, izPrev;
  logic highSideGateDrive, lowSideGateDrive, supplyGoodOutput;
  logic [11:0] paddr, outputSenseInput, outputTarget;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] inputVoltage;
  logic [15:0] dutyCommand, nominalDuty;
  logic [7:0] lightLoad;
  logic [4:0] strapIndex;
  lfs_strap_t strapLevel;
  int failures = 0, checks = 0, deCnt = 0, d0;
  logic [31:0] afMode[4] = '{32'h1, 32'h7, 32'h13, 32'h3};
  lfs_row_s rows[12] = '{'{2'h1, 5'h0, 12'h004, 1'b0, 32'h0, 32'h1f1c2},
    '{2'h0, 5'h0, 12'h004, 1'b0, 32'h0, 32'h1f12c}, '{2'h2, 5'h0, 12'h004, 1'b0, 32'h0, 32'h1f438},
    '{2'h3, 5'h0, 12'h004, 1'b0, 32'h0, 32'h1f11d}, '{2'h3, 5'h5, 12'h004, 1'b0, 32'h0, 32'h1f1cb},
    '{2'h3, 5'h12, 12'h004, 1'b0, 32'h0, 32'h1f640}, '{2'h1, 5'h0, 12'h000, 1'b0, 32'h0, 32'hf00},
    '{2'h1, 5'h0, 12'h008, 1'b0, 32'h0, 32'h2900a4},
    '{2'h1, 5'h0, 12'h004, 1'b1, 32'h1f7d0, 32'h1f640},
    '{2'h1, 5'h0, 12'h004, 1'b1, 32'h1f010, 32'h1f11d},
    '{2'h1, 5'h0, 12'h000, 1'b1, 32'h28, 32'h8}, '{2'h1, 5'h0, 12'h010, 1'b0, 32'h0, 32'h0}};
  lfs_supervisor uut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .strapLevel, .strapIndex, .inputVoltage, .outputSenseInput,
    .outputTarget, .dutyCommand, .nominalDuty, .inductorZero, .highSideGateDrive,
    .lowSideGateDrive, .supplyGoodOutput);
  lfs_power_stage stage (.sys_clk, .arst_n, .highSideGateDrive, .lowSideGateDrive,
    .lightLoad, .inductorZero);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Low side seen on after a zero-current cycle
  always @(posedge sys_clk) begin
    izPrev <= inductorZero;
    if (lowSideGateDrive && izPrev) deCnt <= deCnt + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic rst();
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask : rst
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  task automatic close_out();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial begin
    wt(60000);
    failures++;
    close_out();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, strapIndex, lightLoad} <= '0;
    strapLevel <= 2'h1;
    inputVoltage <= 11'h4b0;
    outputTarget <= 12'h3e8;
    outputSenseInput <= 12'h3e8;
    dutyCommand <= 16'h6000;
    nominalDuty <= 16'h8000;
    foreach (rows[i]) begin
      strapLevel <= rows[i].lv;
      strapIndex <= rows[i].ix;
      rst();
      if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].q);
      chk({31'h0, er}, {31'h0, rows[i].a > 12'h00c});
      $display("row %0d done", i);
    end
    strapLevel <= 2'h1;
    rst();
    wt(2);
    chk({31'h0, supplyGoodOutput}, 32'h1);
    outputSenseInput <= 12'h47e;
    wt(8);
    chk({31'h0, supplyGoodOutput}, 32'h1);
    outputSenseInput <= 12'h47f;
    wt(3);
    chk({30'h0, supplyGoodOutput, highSideGateDrive}, 32'h0);
    outputSenseInput <= 12'h3e8;
    wt(4010);
    chk({31'h0, supplyGoodOutput}, 32'h1);
    apb(1'b1, 12'h000, 32'h20);
    outputSenseInput <= 12'h47f;
    wt(4);
    outputSenseInput <= 12'h3e8;
    wt(2000);
    chk({30'h0, lowSideGateDrive, highSideGateDrive}, 32'h2);
    apb(1'b1, 12'h000, 32'h40);
    $display("overvoltage done");
    inputVoltage <= 11'h100;
    wt(3);
    chk({31'h0, supplyGoodOutput}, 32'h0);
    inputVoltage <= 11'h4b0;
    wt(4010);
    chk({31'h0, supplyGoodOutput}, 32'h1);
    apb(1'b1, 12'h004, 32'h1e1c2);
    inputVoltage <= 11'h100;
    wt(20);
    apb(1'b0, 12'h00c, 32'h0);
    chk({28'h0, supplyGoodOutput, rd[2:0]}, 32'h1);
    apb(1'b1, 12'h004, 32'h1e9c2);
    wt(2010);
    inputVoltage <= 11'h4b0;
    wt(4010);
    apb(1'b0, 12'h00c, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h2);
    apb(1'b1, 12'h000, 32'h40);
    apb(1'b0, 12'h00c, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h1);
    $display("undervoltage done");
    lightLoad <= 8'h14;
    apb(1'b1, 12'h000, 32'h2);
    d0 = deCnt;
    wt(2000);
    chk(32'(deCnt - d0), 32'h0);
    apb(1'b1, 12'h000, 32'h6);
    d0 = deCnt;
    wt(2000);
    chk({31'h0, deCnt > d0}, 32'h1);
    apb(1'b1, 12'h000, 32'h0);
    lightLoad <= 8'h0;
    dutyCommand <= 16'h1000;
    $display("emulation done");
    foreach (afMode[i]) begin
      apb(1'b1, 12'h000, afMode[i]);
      wt(4000);
      apb(1'b0, 12'h00c, 32'h0);
      chk({31'h0, rd[31:16] == 16'ha4}, {31'h0, afMode[i] != 32'h3});
    end
    chk({16'h0, rd[31:16]}, 32'(`LFS_MIN_INC_RST + (`LFS_PROG_INC_RST - `LFS_MIN_INC_RST) / 4));
    dutyCommand <= 16'h6000;
    wt(4000);
    apb(1'b0, 12'h00c, 32'h0);
    chk({16'h0, rd[31:16]}, 32'(`LFS_PROG_INC_RST));
    $display("frequency done");
    close_out();
  end
endmodule : tb_lfs_supervisor
`default_nettype wire
